/* File: design/flash_host_map.vh */
/*
 * constants for the parallel flash host controller: command codes,
 * protection read addresses, bus timing counts and operation timeouts.
 * assumes a 250 MHz system clock (4 ns period).
 */
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH

// clock period in picoseconds
`define CLK_PERIOD_PS      4000
// command bytes
`define CMD_SECTOR_SETUP   8'h20
`define CMD_SECTOR_EXEC    8'hD0
`define CMD_CHIP_ERASE     8'h30
`define CMD_PROGRAM_SETUP  8'h10
`define CMD_ABORT          8'hFF
`define CMD_IDENT          8'h90
// identification addresses
`define ADDR_MAKER_ID      19'h00000
`define ADDR_PART_ID       19'h00001
// protection read sequences (unlock ends 041A, lock ends 040A)
`define UNLOCK_A0          19'h01823
`define UNLOCK_A1          19'h01820
`define UNLOCK_A2          19'h01822
`define UNLOCK_A3          19'h00418
`define UNLOCK_A4          19'h0041B
`define UNLOCK_A5          19'h00419
`define UNLOCK_A6          19'h0041A
`define LOCK_A6            19'h0040A
// operation kinds at the user port
`define OP_READ            3'h0
`define OP_WRITE_CMD       3'h1
`define OP_PROGRAM         3'h2
`define OP_SECTOR_ERASE    3'h3
`define OP_CHIP_ERASE      3'h4
`define OP_UNLOCK          3'h5
`define OP_LOCK            3'h6
`define OP_ABORT           3'h7
// bus strobe phase length in clock cycles (120 ns)
`define PHASE_NS           120
`define PHASE_CYCLES       ((`PHASE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// operation timeouts
`define SECTOR_ERASE_NS    4000000
`define CHIP_ERASE_NS      20000000
`define PROGRAM_NS         1000000
`define SETTLE_NS          1000
// divide by the period in ns so the erase products stay inside 32 bits
`define SECTOR_ERASE_CYC   (`SECTOR_ERASE_NS / (`CLK_PERIOD_PS / 1000))
`define CHIP_ERASE_CYC     (`CHIP_ERASE_NS / (`CLK_PERIOD_PS / 1000))
`define PROGRAM_CYC        (`PROGRAM_NS / (`CLK_PERIOD_PS / 1000))
`define SETTLE_CYC         (`SETTLE_NS / (`CLK_PERIOD_PS / 1000))

`endif

/* File: design/pin_sync.v */
/*
 * three-stage synchroniser for the flash data pins. a change is taken
 * once the second and third stages agree.
 * assumes inputs are asynchronous to clk.
 */
module pin_sync (
   input  wire       clk,
   input  wire       resetn,
   input  wire [7:0] pinIn,
   output reg  [7:0] pinOut
);

   reg [7:0] stage1Q;   // metastability catcher, read only by stage2
   reg [7:0] stage2Q;   // second stage
   reg [7:0] stage3Q;   // third stage

   // shift chain, and accept bits where stages two and three agree
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1Q <= 8'h00;
         stage2Q <= 8'h00;
         stage3Q <= 8'h00;
         pinOut  <= 8'h00;
      end else begin
         stage1Q <= pinIn;
         stage2Q <= stage1Q;
         stage3Q <= stage2Q;
         pinOut  <= (stage2Q & stage3Q) | (pinOut & (stage2Q ^ stage3Q));
      end
   end

endmodule

/* File: design/flash_host.v */
/*
 * host controller for an asynchronous byte-wide flash with command
 * setup/execute pairs, read-sequence write lock and status polling.
 * assumes one 250 MHz clock, a flash wired to the pins below, and a user
 * that holds reqValid with its fields until reqReady pulses.
 */
// Function
// - write strobes with chip select held low
// - sector erase is 20H then D0H
// - timeout flagged on rspTimeout; caller reissues erase
// - chip erase is 30H written twice
// - program is 10H then address/data
// - end detected by toggling-bit polling
// - seven-read unlock and lock sequences
`include "flash_host_map.vh"
module flash_host (
   input  wire        clk,
   input  wire        resetn,
   input  wire        reqValid,     // user request present
   input  wire [2:0]  reqOp,        // operation kind
   input  wire [18:0] reqAddr,      // flash address
   input  wire [7:0]  reqData,      // data or raw command byte
   output reg         reqReady,     // one-cycle pulse: request finished
   output reg  [7:0]  rspData,      // read data, valid with reqReady
   output reg         rspTimeout,   // operation did not finish in time
   output reg         busy,         // request in progress
   output reg         writeLockState, // believed lock state of flash
   output reg  [18:0] flashAddr,    // address pins
   output reg  [7:0]  dataPinsOut,  // data pins, driven value
   output reg         dataPinsOe,   // high while host drives data pins
   input  wire [7:0]  dataPinsIn,   // data pins, sampled value
   output reg         chipSelectN,  // active-low chip select
   output reg         outGateN,     // active-low output gate
   output reg         writeStrobeN  // active-low write strobe
);

   // counts as integers first, then cut to the counter widths on purpose
   localparam integer PHASE_N  = `PHASE_CYCLES;
   localparam integer SECT_N   = `SECTOR_ERASE_CYC;
   localparam integer CHIP_N   = `CHIP_ERASE_CYC;
   localparam integer PROG_N   = `PROGRAM_CYC;
   localparam integer SETTLE_N = `SETTLE_CYC;
   localparam [7:0]   PHASE    = PHASE_N[7:0];
   localparam [23:0]  SECT_TO  = SECT_N[23:0];
   localparam [23:0]  CHIP_TO  = CHIP_N[23:0];
   localparam [23:0]  PROG_TO  = PROG_N[23:0];
   localparam [23:0]  SETTLE   = SETTLE_N[23:0];

   // state codes
   localparam [3:0] S_IDLE  = 4'h0;
   localparam [3:0] S_WSET  = 4'h1;  // address/data set up, strobes high
   localparam [3:0] S_WLOW  = 4'h2;  // write strobe low
   localparam [3:0] S_WHOLD = 4'h3;  // strobe risen, hold address/data
   localparam [3:0] S_RSET  = 4'h4;  // read address set up
   localparam [3:0] S_RLOW  = 4'h5;  // gate low, wait access time
   localparam [3:0] S_RHOLD = 4'h6;  // gate risen, hold address
   localparam [3:0] S_NEXT  = 4'h7;  // pick next bus step
   localparam [3:0] S_SETTL = 4'h8;  // wait after toggling stops
   localparam [3:0] S_DONE  = 4'h9;

   wire [7:0] pinsSync;  // synchronised data pins

   pin_sync syncPins (
      .clk    (clk),
      .resetn (resetn),
      .pinIn  (dataPinsIn),
      .pinOut (pinsSync)
   );

   reg [3:0]  state_q;   // sequencer state
   reg [7:0]  phase_q;   // cycles left in bus phase
   reg [2:0]  step_q;    // bus step within request
   reg [2:0]  op_q;      // latched operation
   reg [18:0] addr_q;    // latched address
   reg [7:0]  data_q;    // latched data
   reg [23:0] wait_q;    // operation timeout counter
   reg        poll_q;    // polling for completion
   reg        havePrev_q; // a previous poll read exists
   reg        prevTog_q; // toggling bit of previous poll read

   // address for the n-th protection read
   function [18:0] seqAddr;
      input [2:0] n;
      input       lock;
      begin
         case (n)
            3'd0:    seqAddr = `UNLOCK_A0;
            3'd1:    seqAddr = `UNLOCK_A1;
            3'd2:    seqAddr = `UNLOCK_A2;
            3'd3:    seqAddr = `UNLOCK_A3;
            3'd4:    seqAddr = `UNLOCK_A4;
            3'd5:    seqAddr = `UNLOCK_A5;
            default: seqAddr = lock ? `LOCK_A6 : `UNLOCK_A6;
         endcase
      end
   endfunction

   // index of the last bus step per request kind (one less than the step count)
   function [2:0] lastStep;
      input [2:0] op;
      begin
         case (op)
            `OP_PROGRAM, `OP_SECTOR_ERASE, `OP_CHIP_ERASE: lastStep = 3'd1;
            `OP_UNLOCK, `OP_LOCK:                         lastStep = 3'd6;
            default:                                      lastStep = 3'd0;
         endcase
      end
   endfunction

   // command byte written at each step
   function [7:0] wrByte;
      input [2:0] op;
      input [2:0] st;
      input [7:0] d;
      begin
         case (op)
            `OP_PROGRAM:      wrByte = st[0] ? d : `CMD_PROGRAM_SETUP;
            `OP_SECTOR_ERASE: wrByte = st[0] ? `CMD_SECTOR_EXEC
                                             : `CMD_SECTOR_SETUP;
            `OP_CHIP_ERASE:   wrByte = `CMD_CHIP_ERASE;
            `OP_ABORT:        wrByte = `CMD_ABORT;
            default:          wrByte = d;
         endcase
      end
   endfunction

   wire isRead = (op_q == `OP_READ) || (op_q == `OP_UNLOCK) || (op_q == `OP_LOCK);
   wire needPoll = (op_q == `OP_PROGRAM) || (op_q == `OP_SECTOR_ERASE) ||
                   (op_q == `OP_CHIP_ERASE);

   // main sequencer: every pin and response is a flip-flop
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q        <= S_IDLE;
         phase_q        <= 8'h00;
         step_q         <= 3'd0;
         op_q           <= `OP_READ;
         addr_q         <= 19'h00000;
         data_q         <= 8'h00;
         wait_q         <= 24'h000000;
         poll_q         <= 1'b0;
         havePrev_q     <= 1'b0;
         prevTog_q      <= 1'b0;
         reqReady       <= 1'b0;
         rspData        <= 8'h00;
         rspTimeout     <= 1'b0;
         busy           <= 1'b0;
         writeLockState <= 1'b1;        // flash powers up locked
         flashAddr      <= 19'h00000;
         dataPinsOut    <= 8'h00;
         dataPinsOe     <= 1'b0;
         chipSelectN    <= 1'b1;        // deselected
         outGateN       <= 1'b1;
         writeStrobeN   <= 1'b1;
      end else begin
         reqReady <= 1'b0;
         if (phase_q != 8'h00)
            phase_q <= phase_q - 8'h01;
         if (poll_q && wait_q != 24'h000000)
            wait_q <= wait_q - 24'h000001;
         case (state_q)
            // take a request
            S_IDLE: begin
               // the finished request may still be held while reqReady stands
               if (reqValid && !reqReady) begin
                  op_q       <= reqOp;
                  addr_q     <= reqAddr;
                  data_q     <= reqData;
                  step_q     <= 3'd0;
                  poll_q     <= 1'b0;
                  havePrev_q <= 1'b0;
                  rspTimeout <= 1'b0;
                  busy       <= 1'b1;
                  state_q    <= S_NEXT;
               end
            end
            // decide what the next bus cycle is
            S_NEXT: begin
               chipSelectN <= 1'b0;
               phase_q     <= PHASE;
               if (poll_q || isRead) begin
                  // read cycle; gate never low together with strobe
                  flashAddr  <= (op_q == `OP_UNLOCK || op_q == `OP_LOCK) ?
                                seqAddr(step_q, op_q == `OP_LOCK) : addr_q;
                  dataPinsOe <= 1'b0;
                  state_q    <= S_RSET;
               end else begin
                  // address settles before the strobe falls
                  flashAddr   <= addr_q;
                  dataPinsOut <= wrByte(op_q, step_q, data_q);
                  dataPinsOe  <= 1'b1;
                  state_q     <= S_WSET;
               end
            end
            S_WSET: if (phase_q == 8'h00) begin
               writeStrobeN <= 1'b0;    // strobe with select low
               phase_q      <= PHASE;
               state_q      <= S_WLOW;
            end
            S_WLOW: if (phase_q == 8'h00) begin
               writeStrobeN <= 1'b1;    // data held through the rise
               phase_q      <= PHASE;
               state_q      <= S_WHOLD;
            end
            S_WHOLD: if (phase_q == 8'h00) begin
               chipSelectN <= 1'b1;
               dataPinsOe  <= 1'b0;
               if (step_q != lastStep(op_q)) begin
                  step_q  <= step_q + 3'd1;
                  state_q <= S_NEXT;
               end else if (needPoll) begin
                  // operation started at the strobe rise
                  poll_q  <= 1'b1;
                  wait_q  <= (op_q == `OP_SECTOR_ERASE) ? SECT_TO :
                             (op_q == `OP_CHIP_ERASE) ? CHIP_TO : PROG_TO;
                  state_q <= S_NEXT;
               end else begin
                  state_q <= S_DONE;
               end
            end
            S_RSET: if (phase_q == 8'h00) begin
               outGateN <= 1'b0;        // read with strobe high
               phase_q  <= PHASE + 8'h03; // covers synchroniser delay
               state_q  <= S_RLOW;
            end
            S_RLOW: if (phase_q == 8'h00) begin
               outGateN <= 1'b1;        // flash releases pins
               rspData  <= pinsSync;
               phase_q  <= PHASE;       // address held past gate rise
               state_q  <= S_RHOLD;
            end
            S_RHOLD: if (phase_q == 8'h00) begin
               chipSelectN <= 1'b1;
               if (poll_q) begin
                  // toggling bit flips while busy
                  havePrev_q <= 1'b1;
                  prevTog_q  <= rspData[6];
                  if (havePrev_q && prevTog_q == rspData[6]) begin
                     poll_q  <= 1'b0;
                     wait_q  <= SETTLE;   // all bits valid after settle
                     state_q <= S_SETTL;
                  end else if (wait_q == 24'h000000) begin
                     // overdue; caller reissues erase
                     poll_q     <= 1'b0;
                     rspTimeout <= 1'b1;
                     state_q    <= S_DONE;
                  end else begin
                     state_q <= S_NEXT;
                  end
               end else if (step_q != lastStep(op_q)) begin
                  step_q  <= step_q + 3'd1;
                  state_q <= S_NEXT;
               end else begin
                  if (op_q == `OP_UNLOCK)
                     writeLockState <= 1'b0;
                  if (op_q == `OP_LOCK)
                     writeLockState <= 1'b1;
                  state_q <= S_DONE;
               end
            end
            S_SETTL: begin
               wait_q <= wait_q - 24'h000001;
               if (wait_q == 24'h000001)
                  state_q <= S_DONE;
            end
            // report; abort leaves lock state untouched
            S_DONE: begin
               reqReady <= 1'b1;
               busy     <= 1'b0;
               state_q  <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

endmodule

/* File: verif/flash_host_properties.sv */
/* pin assertions for the flash host controller, including idle pins while not busy.
   assumes it is bound into flash_host, one clock, reset active low. */
module flash_host_properties (
   input logic        clk,
   input logic        resetn,
   input logic        busy,
   input logic [18:0] flashAddr,
   input logic [7:0]  dataPinsOut,
   input logic        dataPinsOe,
   input logic        chipSelectN,
   input logic        outGateN,
   input logic        writeStrobeN
);
   timeunit 1ns;
   timeprecision 1ps;
   // all properties sample on the system clock and sleep during reset
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_strobe_needs_select: assert property (!writeStrobeN |-> !chipSelectN)
      else $error("write strobe low without chip select");
   a_gate_off_write: assert property (!writeStrobeN |-> outGateN && dataPinsOe)
      else $error("output gate low or data undriven during write");
   a_addr_held_write: assert property (!writeStrobeN |-> $stable(flashAddr))
      else $error("address moved while write strobe low");
   a_data_at_rise: assert property ($rose(writeStrobeN) |->
      !chipSelectN && dataPinsOe && $stable(dataPinsOut))
      else $error("data not held at write strobe rise");
   a_strobe_min_width: assert property ($fell(writeStrobeN) |=> !writeStrobeN [*8])
      else $error("write strobe pulse too short");
   a_no_drive_read: assert property (!outGateN |->
      !dataPinsOe && !chipSelectN && writeStrobeN)
      else $error("read cycle with host driving or strobe low");
   a_addr_held_gate: assert property ($rose(outGateN) |->
      !chipSelectN && $stable(flashAddr))
      else $error("address or select moved at gate rise");
   a_idle_deselect: assert property (!busy |->
      chipSelectN && outGateN && writeStrobeN)
      else $error("pins active while idle");
endmodule
bind flash_host flash_host_properties chk_u (.clk, .resetn, .busy, .flashAddr, .dataPinsOut,
   .dataPinsOe, .chipSelectN, .outGateN, .writeStrobeN);

/* File: verif/flash_dev_model.sv */
/* behavioural model of the byte-wide flash at the host's far side.
   assumes the host pins are wired straight to it; it has no clock. */
module flash_dev_model #(
   parameter logic [7:0] MAKER_ID = 8'h6C, // arbitrary value
   parameter logic [7:0] PART_ID  = 8'h3A  // arbitrary value
) (
   input  logic [18:0] flashAddr,
   input  logic [7:0]  dataPinsOut,
   input  logic        dataPinsOe,
   input  logic        chipSelectN,
   input  logic        outGateN,
   input  logic        writeStrobeN,
   output logic [7:0]  dataPinsIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [int];        // sparse array, absent bytes read erased
   logic [18:0] wrAddr;           // address latched for a write
   logic [18:0] hist [$];         // last seven read addresses
   logic [7:0]  lastLoad = 8'hFF; // byte loaded by the last operation
   logic [7:0]  rdVal = 8'h00;    // byte shown during a read
   logic [7:0]  lastOut = 8'h00;  // byte last shown
   logic        locked = 1'b1;    // power-up protected
   logic        tog = 1'b0;       // status bit that flips per busy read
   logic        wrAct = 1'b0;
   logic        rdAct = 1'b0;
   int          st = 0;           // 0 read, 1 sector, 2 chip, 3 program setup, 4 ident
   int          busyLeft = 0;     // reads that still see busy status
   int          slowReads = 2;    // bench sets this for slow answers
   // released bus shows the inverse of the last byte
   assign dataPinsIn = rdAct ? rdVal : ~lastOut;
   function automatic logic [7:0] peek(int a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction
   task automatic go(logic [7:0] v); // start a self-timed operation
      lastLoad = v;
      busyLeft = slowReads;
   endtask
   task automatic take(logic [7:0] d); // command decoding
      if (locked) return;
      case (st)
         1: if (d == 8'hD0) begin
            for (int i = 0; i < 256; i++) mem.delete(int'({wrAddr[18:8], i[7:0]}));
            go(8'hFF);
         end
         2: if (d == 8'h30) begin
            mem.delete();
            go(8'hFF);
         end
         3: if (d != 8'hFF) begin
            mem[wrAddr] = peek(wrAddr) & d;
            go(d);
         end
         default: st = 0;
      endcase
      // setup codes, ident mode, and a return to read for anything else
      st = (st != 0) ? 0 : (d == 8'h20) ? 1 : (d == 8'h30) ? 2 : (d == 8'h10) ? 3 :
           (d == 8'h90) ? 4 : 0;
   endtask
   // address on the later falling strobe
   always @(negedge writeStrobeN or negedge chipSelectN) begin
      if (!chipSelectN && !writeStrobeN && outGateN) begin
         wrAddr = flashAddr;
         wrAct = 1'b1;
      end
   end
   // data on the earlier rising strobe
   always @(posedge writeStrobeN or posedge chipSelectN) begin
      if (wrAct && outGateN) take(dataPinsOe ? dataPinsOut : 8'hA5);
      wrAct = 1'b0;
   end
   // read start: status while busy, ident bytes or array data
   always @(negedge outGateN or negedge chipSelectN) begin
      if (!chipSelectN && !outGateN && writeStrobeN) begin
         rdAct = 1'b1;
         if (busyLeft > 0) rdVal = {~lastLoad[7], tog, lastLoad[5:0]};
         else if (st == 4 && flashAddr < 2) rdVal = flashAddr[0] ? PART_ID : MAKER_ID;
         else rdVal = peek(flashAddr);
      end
   end
   // read end: address latched on the earlier rise, protection sequences
   always @(posedge outGateN or posedge chipSelectN) begin
      if (rdAct) begin
         rdAct = 1'b0;
         lastOut = rdVal;
         tog = (busyLeft > 0) ? ~tog : tog;
         busyLeft = (busyLeft > 0) ? busyLeft - 1 : 0;
         hist.push_back(flashAddr);
         if (hist.size() > 7) hist.pop_front();
         if (hist.size() == 7 && hist[0] == 19'h01823 && hist[1] == 19'h01820 &&
             hist[2] == 19'h01822 && hist[3] == 19'h00418 && hist[4] == 19'h0041B) begin
            if (hist[5] == 19'h00419 && hist[6] == 19'h0041A) locked = 1'b0;
            if (hist[6] == 19'h0040A) locked = 1'b1;
         end
      end
   end
endmodule

/* File: verif/tb_top.sv */
/* self-checking bench for the flash host controller with a flash model.
   assumes the model and checker files are compiled before this one. */
`include "flash_host_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;        // 250 MHz system clock
   logic        resetn = 1'b0;     // async reset, active low
   logic        reqValid = 1'b0;   // request present
   logic [2:0]  reqOp = 3'h0;
   logic [18:0] reqAddr = 19'h00000;
   logic [7:0]  reqData = 8'h00;
   logic [7:0]  rdData;            // read data of the last request
   int          n_errors = 0;
   int          n_tests = 0;
   wire         reqReady, rspTimeout, busy, writeLockState, dataPinsOe;
   wire         chipSelectN, outGateN, writeStrobeN;
   wire [7:0]   rspData, dataPinsOut, dataPinsIn;
   wire [18:0]  flashAddr;
   flash_host dut_u (.clk, .resetn, .reqValid, .reqOp, .reqAddr, .reqData, .reqReady,
      .rspData, .rspTimeout, .busy, .writeLockState, .flashAddr, .dataPinsOut,
      .dataPinsOe, .dataPinsIn, .chipSelectN, .outGateN, .writeStrobeN);
   flash_dev_model mem_u (.flashAddr, .dataPinsOut, .dataPinsOe, .chipSelectN,
      .outGateN, .writeStrobeN, .dataPinsIn);
   always #2 clk = ~clk; // 4 ns period
   task automatic chk(string what, logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   // one request held until the ready pulse, bounded wait, then no timeout flag
   task automatic doOp(logic [2:0] op, logic [18:0] a, logic [7:0] d);
      int n;
      @(posedge clk);
      reqOp <= op;
      reqAddr <= a;
      reqData <= d;
      reqValid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (reqReady !== 1'b1 && n < 20000);
      rdData = rspData;
      chk("no timeout", 8'h01, 8'((n < 20000) && rspTimeout === 1'b0));
      reqValid <= 1'b0;
   endtask
   task automatic rd(logic [18:0] a, logic [7:0] e, string what);
      doOp(`OP_READ, a, 8'h00);
      chk(what, e, rdData);
   endtask
   task automatic t_locked; // writes refused before unlock
      chk("lock at start", 8'h01, 8'(writeLockState));
      doOp(`OP_PROGRAM, 19'h00100, 8'h5A);
      rd(19'h00100, 8'hFF, "locked program");
      $display("test locked done");
   endtask
   task automatic t_program; // unlock, then back-to-back programs
      doOp(`OP_UNLOCK, 19'h00000, 8'h00);
      chk("lock after unlock", 8'h00, 8'(writeLockState));
      doOp(`OP_PROGRAM, 19'h00155, 8'hA5);
      doOp(`OP_PROGRAM, 19'h00156, 8'h3C);
      doOp(`OP_PROGRAM, 19'h00200, 8'h11);
      rd(19'h00155, 8'hA5, "program a");
      rd(19'h00156, 8'h3C, "program b");
      $display("test program done");
   endtask
   task automatic t_sector; // slow erase of one sector only
      mem_u.slowReads = 6;
      doOp(`OP_SECTOR_ERASE, 19'h001C0, 8'h00);
      mem_u.slowReads = 2;
      rd(19'h00155, 8'hFF, "erased sector");
      rd(19'h00200, 8'h11, "next sector");
      $display("test sector done");
   endtask
   task automatic t_abort; // aborted setups leave memory alone
      doOp(`OP_WRITE_CMD, 19'h00200, `CMD_SECTOR_SETUP);
      doOp(`OP_ABORT, 19'h00200, 8'h00);
      rd(19'h00200, 8'h11, "erase aborted");
      chk("lock after abort", 8'h00, 8'(writeLockState));
      doOp(`OP_WRITE_CMD, 19'h00200, `CMD_SECTOR_SETUP);
      doOp(`OP_WRITE_CMD, 19'h00200, 8'h55);
      rd(19'h00200, 8'h11, "bad execute");
      doOp(`OP_WRITE_CMD, 19'h00200, `CMD_PROGRAM_SETUP);
      doOp(`OP_ABORT, 19'h00200, 8'h00);
      rd(19'h00200, 8'h11, "program aborted");
      $display("test abort done");
   endtask
   task automatic t_ident; // identity bytes, then back to array data
      doOp(`OP_WRITE_CMD, 19'h00000, `CMD_IDENT);
      rd(19'h00000, mem_u.MAKER_ID, "maker byte");
      rd(19'h00001, mem_u.PART_ID, "part byte");
      doOp(`OP_ABORT, 19'h00000, 8'h00);
      rd(19'h00000, 8'hFF, "ident ended");
      $display("test ident done");
   endtask
   task automatic t_chip; // whole array erase, then lock again
      doOp(`OP_CHIP_ERASE, 19'h00000, 8'h00);
      rd(19'h00200, 8'hFF, "chip erased");
      rd(19'h00156, 8'hFF, "chip erased b");
      doOp(`OP_LOCK, 19'h00000, 8'h00);
      chk("lock after lock", 8'h01, 8'(writeLockState));
      doOp(`OP_PROGRAM, 19'h00300, 8'h77);
      rd(19'h00300, 8'hFF, "relocked program");
      $display("test chip done");
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // watchdog: the tests take under ten thousand cycles
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      final_report;
   end
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_locked;
      t_program;
      t_sector;
      t_abort;
      t_ident;
      t_chip;
      final_report;
   end
endmodule
